// ===== hw/ldc_params.svh
`ifndef LDC_PARAMS_SVH
`define LDC_PARAMS_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define LDC_OFS_CTRL 6'h00
`define LDC_OFS_MODE_CURVE 6'h04
`define LDC_OFS_RAMP_EN 6'h08
`define LDC_OFS_CODE0 6'h0c
`define LDC_OFS_CODE1 6'h10
`define LDC_OFS_CODE2 6'h14
`define LDC_OFS_DUTY0 6'h18
`define LDC_OFS_DUTY1 6'h1c
`define LDC_OFS_DUTY2 6'h20
`define LDC_OFS_STATUS 6'h24

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define LDC_CTRL_FS_BIT 0
`define LDC_CTRL_SHDN_BIT 1
`define LDC_CTRL_SHDN_STAT_BIT 2
`define LDC_ANIM_LSB 0
`define LDC_CURVE_LSB 4
`define LDC_RAMP_ON_LSB 0
`define LDC_RAMP_TIME_LSB 4
`define LDC_STAT_BUSY_LSB 24

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define LDC_FS_RESET 1'b0
`define LDC_CODE_RESET 8'h00
`define LDC_DUTY_RESET 8'h00
`define LDC_TIME_RESET 4'h0

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define LDC_CLK_KHZ 100000
`define LDC_OSC_KHZ 6000
`define LDC_OSC_DIV (`LDC_CLK_KHZ / `LDC_OSC_KHZ)
`define LDC_PWM_TOP 8'hfe
`define LDC_RAMP_UNIT_MS 50
`define LDC_RAMP_STEPS 256
`define LDC_STEP_UNIT_CYC ((`LDC_RAMP_UNIT_MS * `LDC_CLK_KHZ) / `LDC_RAMP_STEPS)
`define LDC_SCL_LOW_MS 10
`define LDC_SCL_LOW_CYC (`LDC_SCL_LOW_MS * `LDC_CLK_KHZ)

// ramp time codes above the linear range, in 50 ms units
`define LDC_RAMP_LIN_MAX 4'ha
`define LDC_RAMP_U_B 8'd20
`define LDC_RAMP_U_C 8'd40
`define LDC_RAMP_U_D 8'd80
`define LDC_RAMP_U_E 8'd120
`define LDC_RAMP_U_F 8'd160

`endif

// ===== hw/ldc_pkg.sv
`include "ldc_params.svh"
package ldc_pkg;

    typedef logic [7:0] ldc_duty_t;
    typedef logic [8:0] ldc_cur_t;

    typedef enum logic {
        LDC_BUS_IDLE = 1'b0,
        LDC_BUS_ANSWER = 1'b1
    } ldc_bus_e;

    // perceptual curve: 3-bit exponent, 5-bit mantissa
    function automatic ldc_duty_t ldc_exp_map(input ldc_duty_t x);
        logic [12:0] v;
        v = 13'({8'h20 + {3'h0, x[4:0]}}) << x[7:5];
        if (x == 8'h00) begin
            return 8'h00;
        end else if (x == 8'hff) begin
            return 8'hff;
        end else begin
            return v[12:5];
        end
    endfunction

    // ramp time code to 50 ms units
    function automatic logic [7:0] ldc_ramp_units(input logic [3:0] code);
        case (code)
            4'hb: return `LDC_RAMP_U_B;
            4'hc: return `LDC_RAMP_U_C;
            4'hd: return `LDC_RAMP_U_D;
            4'he: return `LDC_RAMP_U_E;
            4'hf: return `LDC_RAMP_U_F;
            default: return {4'h0, code};
        endcase
    endfunction

endpackage

// ===== hw/ldc_chan.sv
`timescale 1ns/1ps
`include "ldc_params.svh"

module ldc_chan #(
    parameter int STEP_UNIT_CYC = `LDC_STEP_UNIT_CYC
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire ldc_pkg::ldc_duty_t target,
    input wire logic ramp_on,
    input wire logic [3:0] time_code,
    input wire logic auto_sel,
    input wire ldc_pkg::ldc_duty_t anim_duty,
    input wire logic curve_sel,
    input wire ldc_pkg::ldc_duty_t pwm_cnt,
    input wire logic shutdown,
    output logic pwm_out,
    output ldc_pkg::ldc_duty_t present
);
    import ldc_pkg::*;

    logic [31:0] step_cnt_reg;
    logic [31:0] interval;
    logic [7:0] units;
    ldc_duty_t sel_duty;
    ldc_duty_t shaped;

    assign units = ldc_ramp_units(time_code);
    assign interval = 32'(units) * 32'(STEP_UNIT_CYC);

    // ------------------------------------------------------------
    // ramp
    // ------------------------------------------------------------
    // a new target mid-ramp just redirects from the present value
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            present <= `LDC_DUTY_RESET;
            step_cnt_reg <= 32'h0;
        end else if (!ramp_on || units == 8'h00) begin
            present <= target;
            step_cnt_reg <= 32'h0;
        end else if (present == target) begin
            step_cnt_reg <= 32'h0;
        end else if (step_cnt_reg >= interval - 32'h1) begin
            step_cnt_reg <= 32'h0;
            // one of 256 steps per T/256
            if (present < target) begin
                present <= present + 8'h1;
            end else begin
                present <= present - 8'h1;
            end
        end else begin
            step_cnt_reg <= step_cnt_reg + 32'h1;
        end
    end

    // ------------------------------------------------------------
    // source, curve, compare
    // ------------------------------------------------------------
    assign sel_duty = auto_sel ? anim_duty : present;
    // curve after the ramp so the ramp walks the curve
    assign shaped = curve_sel ? ldc_exp_map(sel_duty) : sel_duty;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pwm_out <= 1'b0;
        end else begin
            pwm_out <= !shutdown && (pwm_cnt < shaped);
        end
    end

    AST_RAMP_ONE_STEP: assert property (@(posedge sys_clk) disable iff (rst)
        ramp_on && $past(ramp_on) && units != 8'h00 && $past(units) != 8'h00
        |-> (present - $past(present) == 8'h1) || ($past(present) - present == 8'h1)
            || present == $past(present))
        else $error("ramp moved by more than one step");

    AST_DIRECT_NOW: assert property (@(posedge sys_clk) disable iff (rst)
        !ramp_on ##1 !ramp_on |-> present == $past(target))
        else $error("direct duty not applied at once");

    AST_ANIM_SRC: assert property (@(posedge sys_clk) disable iff (rst)
        auto_sel && !curve_sel && !shutdown |=> pwm_out == ($past(pwm_cnt) < $past(anim_duty)))
        else $error("animation duty not used");

    AST_LIN_FULL: assert property (@(posedge sys_clk) disable iff (rst)
        !shutdown && !curve_sel && sel_duty == 8'hff |=> pwm_out)
        else $error("full duty not fully on");

    AST_ZERO_OFF: assert property (@(posedge sys_clk) disable iff (rst)
        shaped == 8'h00 |=> !pwm_out)
        else $error("zero duty not off");

    AST_EXP_TRACK: assert property (@(posedge sys_clk) disable iff (rst)
        curve_sel && !auto_sel && !shutdown
        |=> pwm_out == ($past(pwm_cnt) < ldc_exp_map($past(present))))
        else $error("curve not applied");

endmodule

// ===== hw/ldc_core.sv
// Operation
// - global full-scale bit, 25.5/51 mA, resets 0
// - per-channel 8-bit current code, resets zero
// - current equals full-scale times code over 255
// - average current is current times duty
// - 8-bit pwm near 24.5 kHz from a 6.25 MHz tick
// - animation off: duty from direct register
// - ramp off: new duty applies at once
// - ramp on: duty slides to new value
// - animation on: duty from animation input
// - per-channel linear or exponential curve select
// - ramp spans 256 steps over period T
// - ramp can step along exponential curve
// - 4-bit ramp time code table
// - shutdown by command or long low clock
`timescale 1ns/1ps
`include "ldc_params.svh"

module ldc_core #(
    parameter int STEP_UNIT_CYC = `LDC_STEP_UNIT_CYC,
    parameter int SCL_LOW_CYC = `LDC_SCL_LOW_CYC
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic scl_in,
    input wire ldc_pkg::ldc_duty_t anim_duty0,
    input wire ldc_pkg::ldc_duty_t anim_duty1,
    input wire ldc_pkg::ldc_duty_t anim_duty2,
    output logic pwm_out0,
    output logic pwm_out1,
    output logic pwm_out2,
    output ldc_pkg::ldc_cur_t current0,
    output ldc_pkg::ldc_cur_t current1,
    output ldc_pkg::ldc_cur_t current2,
    output logic shutdown
);
    import ldc_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    ldc_bus_e bus_reg;
    logic full_scale_bit;
    logic shdn_cmd_reg;
    logic shdn_scl_reg;
    logic [31:0] scl_low_cnt_reg;
    logic [2:0] animation_select;
    logic [2:0] curve_select;
    logic [2:0] ramp_on;
    logic [3:0] ramp_time_code;
    ldc_duty_t channel_current_code [0:2];
    ldc_duty_t direct_duty [0:2];
    ldc_duty_t anim_duty [0:2];
    ldc_duty_t present [0:2];
    logic [2:0] pwm_bits;
    ldc_cur_t cur_next [0:2];
    logic [4:0] osc_div_reg;
    logic osc_tick;
    ldc_duty_t pwm_cnt_reg;
    logic access;
    logic wr_en;
    logic [31:0] rd_next;

    assign anim_duty[0] = anim_duty0;
    assign anim_duty[1] = anim_duty1;
    assign anim_duty[2] = anim_duty2;

    // ------------------------------------------------------------
    // avalon slave
    // ------------------------------------------------------------
    // one wait cycle per access; idle waitrequest stays high
    assign access = (avs_read || avs_write) && bus_reg == LDC_BUS_IDLE;
    assign wr_en = avs_write && bus_reg == LDC_BUS_ANSWER && avs_byteenable[0];

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            bus_reg <= LDC_BUS_IDLE;
            avs_waitrequest <= 1'b1;
        end else begin
            case (bus_reg)
                LDC_BUS_IDLE: begin
                    if (access) begin
                        bus_reg <= LDC_BUS_ANSWER;
                        avs_waitrequest <= 1'b0;
                    end
                end
                LDC_BUS_ANSWER: begin
                    bus_reg <= LDC_BUS_IDLE;
                    avs_waitrequest <= 1'b1;
                end
                default: begin
                    bus_reg <= LDC_BUS_IDLE;
                    avs_waitrequest <= 1'b1;
                end
            endcase
        end
    end

    always_comb begin
        rd_next = 32'h0;
        case (avs_address)
            `LDC_OFS_CTRL: begin
                rd_next[`LDC_CTRL_FS_BIT] = full_scale_bit;
                rd_next[`LDC_CTRL_SHDN_BIT] = shdn_cmd_reg;
                rd_next[`LDC_CTRL_SHDN_STAT_BIT] = shutdown;
            end
            `LDC_OFS_MODE_CURVE: begin
                rd_next[`LDC_ANIM_LSB +: 3] = animation_select;
                rd_next[`LDC_CURVE_LSB +: 3] = curve_select;
            end
            `LDC_OFS_RAMP_EN: begin
                rd_next[`LDC_RAMP_ON_LSB +: 3] = ramp_on;
                rd_next[`LDC_RAMP_TIME_LSB +: 4] = ramp_time_code;
            end
            `LDC_OFS_CODE0: rd_next[7:0] = channel_current_code[0];
            `LDC_OFS_CODE1: rd_next[7:0] = channel_current_code[1];
            `LDC_OFS_CODE2: rd_next[7:0] = channel_current_code[2];
            `LDC_OFS_DUTY0: rd_next[7:0] = direct_duty[0];
            `LDC_OFS_DUTY1: rd_next[7:0] = direct_duty[1];
            `LDC_OFS_DUTY2: rd_next[7:0] = direct_duty[2];
            `LDC_OFS_STATUS: begin
                rd_next[23:0] = {present[2], present[1], present[0]};
                for (int i = 0; i < 3; i++) begin
                    rd_next[`LDC_STAT_BUSY_LSB + i] = present[i] != direct_duty[i];
                end
            end
            default: rd_next = 32'h0;
        endcase
    end

    // read data taken with the edge that drops waitrequest
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            avs_readdata <= 32'h0;
        end else if (access && avs_read) begin
            avs_readdata <= rd_next;
        end
    end

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            full_scale_bit <= `LDC_FS_RESET;
            shdn_cmd_reg <= 1'b0;
            animation_select <= 3'h0;
            curve_select <= 3'h0;
            ramp_on <= 3'h0;
            ramp_time_code <= `LDC_TIME_RESET;
            for (int i = 0; i < 3; i++) begin
                channel_current_code[i] <= `LDC_CODE_RESET;
                direct_duty[i] <= `LDC_DUTY_RESET;
            end
        end else if (wr_en) begin
            case (avs_address)
                `LDC_OFS_CTRL: begin
                    full_scale_bit <= avs_writedata[`LDC_CTRL_FS_BIT];
                    shdn_cmd_reg <= avs_writedata[`LDC_CTRL_SHDN_BIT];
                end
                `LDC_OFS_MODE_CURVE: begin
                    animation_select <= avs_writedata[`LDC_ANIM_LSB +: 3];
                    curve_select <= avs_writedata[`LDC_CURVE_LSB +: 3];
                end
                `LDC_OFS_RAMP_EN: begin
                    ramp_on <= avs_writedata[`LDC_RAMP_ON_LSB +: 3];
                    ramp_time_code <= avs_writedata[`LDC_RAMP_TIME_LSB +: 4];
                end
                `LDC_OFS_CODE0: channel_current_code[0] <= avs_writedata[7:0];
                `LDC_OFS_CODE1: channel_current_code[1] <= avs_writedata[7:0];
                `LDC_OFS_CODE2: channel_current_code[2] <= avs_writedata[7:0];
                `LDC_OFS_DUTY0: direct_duty[0] <= avs_writedata[7:0];
                `LDC_OFS_DUTY1: direct_duty[1] <= avs_writedata[7:0];
                `LDC_OFS_DUTY2: direct_duty[2] <= avs_writedata[7:0];
                default: begin
                end
            endcase
        end
    end

    AST_FS_WRITE: assert property (@(posedge sys_clk) disable iff (rst)
        avs_write && !avs_waitrequest && avs_byteenable[0] && avs_address == `LDC_OFS_CTRL
        |=> full_scale_bit == $past(avs_writedata[`LDC_CTRL_FS_BIT]))
        else $error("full-scale bit not written");

    AST_BUS_ANSWER: assert property (@(posedge sys_clk) disable iff (rst)
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer not one cycle");

    // ------------------------------------------------------------
    // shutdown
    // ------------------------------------------------------------
    // clock held low long enough means the host wants sleep
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            scl_low_cnt_reg <= 32'h0;
            shdn_scl_reg <= 1'b0;
        end else if (scl_in) begin
            scl_low_cnt_reg <= 32'h0;
            shdn_scl_reg <= 1'b0;
        end else if (scl_low_cnt_reg >= 32'(SCL_LOW_CYC - 1)) begin
            shdn_scl_reg <= 1'b1;
        end else begin
            scl_low_cnt_reg <= scl_low_cnt_reg + 32'h1;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            shutdown <= 1'b0;
        end else begin
            shutdown <= shdn_cmd_reg || shdn_scl_reg;
        end
    end

    AST_SCL_SHDN: assert property (@(posedge sys_clk) disable iff (rst)
        shdn_scl_reg |=> shutdown)
        else $error("long low clock did not shut down");

    // ------------------------------------------------------------
    // pwm time base
    // ------------------------------------------------------------
    // whole divide truncates: tick 6.25 MHz, period near 24.5 kHz, no jitter
    assign osc_tick = osc_div_reg == 5'(`LDC_OSC_DIV - 1);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            osc_div_reg <= 5'h0;
        end else if (osc_tick) begin
            osc_div_reg <= 5'h0;
        end else begin
            osc_div_reg <= osc_div_reg + 5'h1;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pwm_cnt_reg <= 8'h00;
        end else if (osc_tick) begin
            // top of 254 so a setting of 255 never goes low
            pwm_cnt_reg <= (pwm_cnt_reg == `LDC_PWM_TOP) ? 8'h00 : pwm_cnt_reg + 8'h1;
        end
    end

    AST_PWM_WRAP: assert property (@(posedge sys_clk) disable iff (rst)
        osc_tick && pwm_cnt_reg == `LDC_PWM_TOP |=> pwm_cnt_reg == 8'h00)
        else $error("pwm period wrong");

    // ------------------------------------------------------------
    // channels
    // ------------------------------------------------------------
    for (genvar g = 0; g < 3; g++) begin : g_chan
        ldc_chan #(
            .STEP_UNIT_CYC(STEP_UNIT_CYC)
        ) u_chan (
            .sys_clk(sys_clk),
            .rst(rst),
            .target(direct_duty[g]),
            .ramp_on(ramp_on[g]),
            .time_code(ramp_time_code),
            .auto_sel(animation_select[g]),
            .anim_duty(anim_duty[g]),
            .curve_sel(curve_select[g]),
            .pwm_cnt(pwm_cnt_reg),
            .shutdown(shutdown),
            .pwm_out(pwm_bits[g]),
            .present(present[g])
        );
    end

    assign pwm_out0 = pwm_bits[0];
    assign pwm_out1 = pwm_bits[1];
    assign pwm_out2 = pwm_bits[2];

    // ------------------------------------------------------------
    // analog current
    // ------------------------------------------------------------
    // in 0.1 mA units: 25.5 mA scale is code, 51 mA scale is twice code
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            cur_next[i] = {1'b0, channel_current_code[i]} << full_scale_bit;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            current0 <= 9'h000;
            current1 <= 9'h000;
            current2 <= 9'h000;
        end else begin
            // gated with pwm downstream, giving the product average
            current0 <= shutdown ? 9'h000 : cur_next[0];
            current1 <= shutdown ? 9'h000 : cur_next[1];
            current2 <= shutdown ? 9'h000 : cur_next[2];
        end
    end

    AST_CUR_SCALE: assert property (@(posedge sys_clk) disable iff (rst)
        !shutdown |=> current0 == ({1'b0, $past(channel_current_code[0])} << $past(full_scale_bit)))
        else $error("current scale wrong");

    AST_CUR_ZERO: assert property (@(posedge sys_clk) disable iff (rst)
        channel_current_code[1] == 8'h00 |=> current1 == 9'h000)
        else $error("zero code gives current");

endmodule

// ===== testbench/ldc_led_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// led sink model
// ------------------------------------------------------------
module ldc_led_model (
    input wire logic sys_clk,
    input wire logic clr,
    input wire logic [2:0] sink_on,
    input wire ldc_pkg::ldc_cur_t cur [3],
    output logic [15:0] lit [3],
    output logic [31:0] chg [3]
);
    import ldc_pkg::*;
    // charge is summed per clock, so the mean current needs no division here
    always_ff @(posedge sys_clk) begin
        for (int i = 0; i < 3; i++) begin
            if (clr) begin
                lit[i] <= '0;
                chg[i] <= '0;
            end else if (sink_on[i]) begin
                lit[i] <= lit[i] + 16'h0001;
                chg[i] <= chg[i] + 32'(cur[i]);
            end
        end
    end
endmodule

// ===== testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
    import ldc_pkg::*;
    localparam int PER = 255 * 16;
    typedef struct {logic [31:0] val; logic [31:0] mask;} ldc_note_s;
    logic sys_clk, rst, avs_read, avs_write, avs_waitrequest, scl_in, shutdown, clr;
    logic [5:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0] avs_byteenable;
    logic [2:0] pwm;
    ldc_duty_t anim [3];
    ldc_cur_t cur [3];
    logic [15:0] lit [3];
    logic [31:0] chg [3];
    logic [7:0] code [3];
    logic [7:0] d;
    ldc_note_s notes [$];
    ldc_note_s nt;
    int error_cnt = 0;
    int cmp_count = 0;
    int ch;

    ldc_core #(.STEP_UNIT_CYC(2), .SCL_LOW_CYC(20)) uut (
        .sys_clk(sys_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .scl_in(scl_in), .anim_duty0(anim[0]),
        .anim_duty1(anim[1]), .anim_duty2(anim[2]), .pwm_out0(pwm[0]),
        .pwm_out1(pwm[1]), .pwm_out2(pwm[2]), .current0(cur[0]), .current1(cur[1]),
        .current2(cur[2]), .shutdown(shutdown)
    );
    ldc_led_model led (.sys_clk(sys_clk), .clr(clr), .sink_on(pwm), .cur(cur), .lit(lit),
        .chg(chg));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] wd,
        input logic [3:0] be);
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= wd;
        avs_byteenable <= be;
        avs_read <= !w;
        avs_write <= w;
        // no cycle limit here: only the watchdog ends a hung access
        do begin
            @(posedge sys_clk);
        end while (avs_waitrequest !== 1'b0);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] wd);
        bus(1'b1, a, wd, 4'h1);
    endtask
    task automatic rdc(input logic [5:0] a, input logic [31:0] e, input logic [31:0] m);
        notes.push_back('{e, m});
        bus(1'b0, a, 32'h0, 4'hf);
    endtask
    // one full pwm period, so the phase at which counting starts does not matter
    task automatic measure(input int c, input logic [31:0] hi, input logic [31:0] q);
        repeat (4) @(posedge sys_clk);
        clr <= 1'b1;
        @(posedge sys_clk);
        clr <= 1'b0;
        repeat (PER + 1) @(posedge sys_clk);
        check("lit cycles", 32'(lit[c]), hi);
        check("charge", chg[c], q);
    endtask
    task automatic waitc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    function automatic logic [7:0] curve(input logic [7:0] x);
        logic [12:0] v;
        v = 13'(8'h20 + x[4:0]) << x[7:5];
        return (x == 8'h00) ? 8'h00 : (x == 8'hff) ? 8'hff : v[12:5];
    endfunction

    always @(posedge sys_clk) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
            if (notes.size() == 0) begin
                error_cnt++;
            end else begin
                nt = notes.pop_front();
                check("readdata", avs_readdata & nt.mask, nt.val & nt.mask);
            end
        end
    end

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    initial begin
        #700000;
        error_cnt++;
        complete_run();
    end

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        rst = 1'b1;
        {avs_read, avs_write, clr, scl_in} = 4'h1;
        avs_address = 6'h00;
        avs_writedata = 32'h0;
        avs_byteenable = 4'h0;
        anim = '{8'h00, 8'h00, 8'h00};
        void'($urandom(45));
        waitc(3);
        rst <= 1'b0;
        rdc(6'h00, 32'h0, 32'hffffffff);
        rdc(6'h0c, 32'h0, 32'hff);
        rdc(6'h3c, 32'h0, 32'hffffffff);
        check("current0", 32'(cur[0]), 32'h0);
        $display("test reset done");
        for (int i = 0; i < 3; i++) begin
            code[i] = 8'($urandom_range(1, 255));
            wr(6'h0c + 6'(4 * i), 32'(code[i]));
        end
        waitc(2);
        for (int i = 0; i < 3; i++) check("current", 32'(cur[i]), 32'(code[i]));
        wr(6'h00, 32'h1);
        waitc(2);
        for (int i = 0; i < 3; i++) check("current", 32'(cur[i]), 32'(code[i]) * 2);
        $display("test current done");
        for (int k = 0; k < 5; k++) begin
            ch = (k < 3) ? 0 : k - 2;
            d = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : 8'($urandom);
            wr(6'h18 + 6'(4 * ch), 32'(d));
            measure(ch, 32'(d) * 16, 32'(d) * 32 * 32'(code[ch]));
        end
        $display("test linear done");
        anim[1] <= 8'($urandom);
        d = 8'($urandom);
        wr(6'h04, 32'h12);
        wr(6'h18, 32'(d));
        measure(0, 32'(curve(d)) * 16, 32'(curve(d)) * 32 * 32'(code[0]));
        measure(1, 32'(anim[1]) * 16, 32'(anim[1]) * 32 * 32'(code[1]));
        wr(6'h04, 32'h0);
        $display("test curve done");
        wr(6'h18, 32'h33);
        rdc(6'h24, 32'h33, 32'h070000ff);
        wr(6'h08, 32'h11);
        wr(6'h18, 32'h43);
        rdc(6'h24, 32'h01000000, 32'h01000000);
        waitc(60);
        rdc(6'h24, 32'h43, 32'h010000ff);
        wr(6'h18, 32'h03);
        waitc(20);
        wr(6'h18, 32'h53);
        waitc(36);
        // down 11 steps to 38, then back up 19 steps from there
        rdc(6'h24, 32'h0100004b, 32'h010000ff);
        waitc(80);
        rdc(6'h24, 32'h53, 32'h010000ff);
        wr(6'h08, 32'hb1);
        wr(6'h18, 32'h33);
        waitc(1200);
        // code b is 20 units of 2 cycles: 30 steps so far
        rdc(6'h24, 32'h01000035, 32'h010000ff);
        waitc(150);
        rdc(6'h24, 32'h33, 32'h010000ff);
        bus(1'b1, 6'h18, 32'hff, 4'he);
        rdc(6'h18, 32'h33, 32'hff);
        $display("test ramp done");
        wr(6'h00, 32'h2);
        waitc(3);
        check("shutdown", 32'(shutdown), 32'h1);
        check("current", 32'(cur[0]), 32'h0);
        rdc(6'h00, 32'h6, 32'h6);
        measure(0, 32'h0, 32'h0);
        wr(6'h00, 32'h0);
        waitc(3);
        check("shutdown", 32'(shutdown), 32'h0);
        scl_in <= 1'b0;
        waitc(15);
        check("shutdown", 32'(shutdown), 32'h0);
        waitc(15);
        check("shutdown", 32'(shutdown), 32'h1);
        scl_in <= 1'b1;
        waitc(6);
        check("shutdown", 32'(shutdown), 32'h0);
        $display("test shutdown done");
        complete_run();
    end

    task automatic complete_run();
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
endmodule
